/* File: logic/modbus_exception_responder.v */
/*
 * Exception decision and exception frame builder for a Modbus RTU slave,
 * with an AHB-Lite register slave for mode control and status.
 * Assumes the framer hands over a checked query summary as a one-cycle
 * strobe and accepts reply bytes by a valid/ready handshake.
 */
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "exception_responder_regs.vh"

module modbus_exception_responder (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Query summary from the framer
    input wire query_valid,
    input wire [7:0] query_slave_addr,
    input wire [7:0] query_function,
    input wire [15:0] query_start_addr,
    input wire [15:0] query_count,
    input wire [7:0] query_byte_count,
    input wire [15:0] query_sub_function,
    input wire query_too_long,
    input wire query_value_out_of_range,
    // Slave condition pins
    input wire tool_busy_pin,
    input wire internal_processing_busy_pin,
    input wire nv_alarm_pin,
    input wire exec_disabled_pin,
    // Decision towards the function handlers
    output reg normal_go,
    output reg [7:0] comm_error_code,
    // Reply byte stream
    output reg tx_valid,
    output reg [7:0] tx_data,
    output reg tx_last,
    input wire tx_ready
);

// ---------------------------------------------------------------
// Pin synchronisers
// ---------------------------------------------------------------
reg [3:0] pin_meta_reg;
reg [3:0] pin_sync_reg;
wire tool_busy;
wire nv_busy;
wire nv_alarm;
wire exec_disabled;

// Two flops on every asynchronous condition pin.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        pin_meta_reg <= 4'h0;
        pin_sync_reg <= 4'h0;
    end else begin
        pin_meta_reg <= {exec_disabled_pin, nv_alarm_pin,
                         internal_processing_busy_pin, tool_busy_pin};
        pin_sync_reg <= pin_meta_reg;
    end
end

assign tool_busy = pin_sync_reg[0];
assign nv_busy = pin_sync_reg[1];
assign nv_alarm = pin_sync_reg[2];
assign exec_disabled = pin_sync_reg[3];

// ---------------------------------------------------------------
// AHB-Lite register slave
// ---------------------------------------------------------------
reg [31:0] control_reg;
reg [7:0] last_exc_reg;
reg [7:0] last_cerr_reg;
reg [15:0] exc_count_reg;
reg [2:0] state_reg; // Sender state; the status register shows only whether it is not idle.
reg wr_pend_reg;
reg [11:0] wr_addr_reg;
wire addr_phase;
wire reply_mode;

assign addr_phase = hsel && hready && htrans[1];
assign reply_mode = control_reg[`CTL_REPLY_MODE_BIT];

// Reads return data in the data phase; writes land at its end. Zero wait.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h00000000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 12'h000;
        control_reg <= `CTL_RESET_VALUE;
    end else begin
        wr_pend_reg <= addr_phase && hwrite;
        if (addr_phase) begin
            wr_addr_reg <= haddr;
        end
        if (wr_pend_reg && wr_addr_reg == `OFS_CONTROL) begin
            control_reg <= {31'h00000000, hwdata[`CTL_REPLY_MODE_BIT]};
        end
        if (addr_phase && !hwrite) begin
            case (haddr)
                `OFS_CONTROL: hrdata <= control_reg;
                `OFS_STATUS: hrdata <= {27'h0000000, state_reg != 3'h0,
                                        pin_sync_reg};
                `OFS_LAST_CODES: hrdata <= {16'h0000, last_cerr_reg, last_exc_reg};
                `OFS_COUNT: hrdata <= {16'h0000, exc_count_reg};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
end

// ---------------------------------------------------------------
// Exception decision
// ---------------------------------------------------------------
reg [7:0] exc_code;
reg [7:0] cerr_code;
reg slave_err;
wire func_known;
wire [16:0] addr_sum;
wire [15:0] max_count;
wire count_is_write;

assign func_known = query_function == `FC_READ || query_function == `FC_WRITE_ONE ||
                    query_function == `FC_DIAG || query_function == `FC_WRITE_MULTI ||
                    query_function == `FC_READ_WRITE;
assign addr_sum = {1'b0, query_start_addr} + {1'b0, query_count};
assign count_is_write = query_function == `FC_WRITE_MULTI;
assign max_count = (query_function == `FC_READ || query_function == `FC_READ_WRITE) ?
                   `MAX_READ_COUNT :
                   (count_is_write ? `MAX_WRITE_COUNT : 16'h0001);

// Checks in fixed precedence: function, address, data, slave.
always @* begin
    exc_code = 8'h00;
    cerr_code = `CERR_NONE;
    slave_err = 1'b0;
    if (!func_known) begin
        exc_code = `EXC_INVALID_FUNCTION;
        cerr_code = `CERR_FUNC_ADDR;
    end else if (query_function == `FC_DIAG) begin
        if (query_sub_function != `DIAG_SUB_ECHO) begin
            exc_code = `EXC_INVALID_FUNCTION;
            cerr_code = `CERR_FUNC_ADDR;
        end
    end else if (query_start_addr > `ADDR_LAST) begin
        exc_code = `EXC_INVALID_ADDRESS;
        cerr_code = `CERR_FUNC_ADDR;
    end else if (query_function != `FC_WRITE_ONE && addr_sum >= `ADDR_END) begin
        exc_code = `EXC_INVALID_ADDRESS;
        cerr_code = `CERR_FUNC_ADDR;
    end else if (query_function != `FC_WRITE_ONE && query_count == 16'h0000) begin
        exc_code = `EXC_INVALID_DATA;
        cerr_code = `CERR_DATA_RANGE;
    end else if (count_is_write && {8'h00, query_byte_count} != {query_count[14:0], 1'b0}) begin
        exc_code = `EXC_INVALID_DATA;
        cerr_code = `CERR_DATA_RANGE;
    end else if (query_too_long || (query_function != `FC_WRITE_ONE &&
                                    query_count > max_count)) begin
        exc_code = `EXC_INVALID_DATA;
        cerr_code = `CERR_DATA_RANGE;
    end else if (tool_busy) begin
        exc_code = `EXC_SLAVE_ERROR;
        cerr_code = `CERR_TOOL_BUSY;
        slave_err = 1'b1;
    end else if (nv_busy || nv_alarm) begin
        exc_code = `EXC_SLAVE_ERROR;
        cerr_code = `CERR_NV_BUSY;
        slave_err = 1'b1;
    end else if (query_value_out_of_range) begin
        exc_code = `EXC_SLAVE_ERROR;
        cerr_code = `CERR_DATA_RANGE;
        slave_err = 1'b1;
    end else if (exec_disabled) begin
        exc_code = `EXC_SLAVE_ERROR;
        cerr_code = `CERR_EXEC_DISABLED;
        slave_err = 1'b1;
    end
end

// ---------------------------------------------------------------
// Exception frame sender
// ---------------------------------------------------------------
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_FUNC = 3'h2;
localparam ST_CODE = 3'h3;
localparam ST_CRCW = 3'h4;
localparam ST_CRCL = 3'h5;
localparam ST_CRCH = 3'h6;

reg [7:0] addr_hold_reg;
reg [7:0] func_hold_reg;
reg [7:0] code_hold_reg;
reg [1:0] feed_idx_reg;
reg crc_feed;
reg crc_clear;
wire crc_busy;
wire [15:0] crc_value;
wire [7:0] feed_byte;
wire send_exc;
wire silent;

assign silent = query_slave_addr == `BROADCAST_ADDR;
assign send_exc = exc_code != 8'h00 && !(slave_err && !reply_mode);

crc16_engine crc_unit (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(crc_clear),
    .byte_valid(crc_feed),
    .byte_data(feed_byte),
    .busy(crc_busy),
    .crc(crc_value)
);

// Header bytes reach the CRC from the hold registers at the engine's own pace.
// Feeding them as the link takes them would drop bytes while the engine shifts.
assign feed_byte = (feed_idx_reg == 2'h0) ? addr_hold_reg :
                   ((feed_idx_reg == 2'h1) ? func_hold_reg : code_hold_reg);

// One header byte goes in whenever the engine is free and bytes remain.
always @* begin
    crc_feed = state_reg != ST_IDLE && feed_idx_reg != 2'h3 && !crc_busy;
    crc_clear = query_valid && state_reg == ST_IDLE;
end

// Sequencer: address, function+80h, code, then CRC low and high.
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_reg <= ST_IDLE;
        tx_valid <= 1'b0;
        tx_data <= 8'h00;
        tx_last <= 1'b0;
        normal_go <= 1'b0;
        comm_error_code <= 8'h00;
        addr_hold_reg <= 8'h00;
        func_hold_reg <= 8'h00;
        code_hold_reg <= 8'h00;
        last_exc_reg <= 8'h00;
        last_cerr_reg <= 8'h00;
        exc_count_reg <= 16'h0000;
        feed_idx_reg <= 2'h3;
    end else begin
        normal_go <= 1'b0;
        if (crc_feed) begin
            feed_idx_reg <= feed_idx_reg + 2'h1;
        end
        case (state_reg)
            ST_IDLE: begin
                if (query_valid) begin
                    comm_error_code <= cerr_code;
                    if (exc_code != 8'h00) begin
                        last_exc_reg <= exc_code;
                        last_cerr_reg <= cerr_code;
                        exc_count_reg <= exc_count_reg + 16'h0001;
                    end
                    if (!send_exc) begin
                        normal_go <= 1'b1;
                    end else if (!silent) begin
                        addr_hold_reg <= query_slave_addr;
                        func_hold_reg <= query_function | `FC_EXCEPTION_FLAG;
                        code_hold_reg <= exc_code;
                        feed_idx_reg <= 2'h0;
                        tx_data <= query_slave_addr;
                        tx_valid <= 1'b1;
                        state_reg <= ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (tx_ready) begin
                    tx_data <= func_hold_reg;
                    state_reg <= ST_FUNC;
                end
            end
            ST_FUNC: begin
                if (tx_ready) begin
                    tx_data <= code_hold_reg;
                    state_reg <= ST_CODE;
                end
            end
            ST_CODE: begin
                if (tx_ready) begin
                    tx_valid <= 1'b0;
                    state_reg <= ST_CRCW;
                end
            end
            ST_CRCW: begin
                if (feed_idx_reg == 2'h3 && !crc_busy) begin
                    tx_data <= crc_value[7:0];
                    tx_valid <= 1'b1;
                    state_reg <= ST_CRCL;
                end
            end
            ST_CRCL: begin
                if (tx_ready) begin
                    tx_data <= crc_value[15:8];
                    tx_last <= 1'b1;
                    state_reg <= ST_CRCH;
                end
            end
            ST_CRCH: begin
                if (tx_ready) begin
                    tx_valid <= 1'b0;
                    tx_last <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            end
            default: begin
                state_reg <= ST_IDLE;
                tx_valid <= 1'b0;
                tx_last <= 1'b0;
            end
        endcase
    end
end

endmodule

/* File: logic/exception_responder_regs.vh */
/*
 * Constants of the exception responder: register offsets, fields, codes, limits.
 * Assumes inclusion by its bare name from the design files.
 */
`ifndef EXCEPTION_RESPONDER_REGS_VH
`define EXCEPTION_RESPONDER_REGS_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_CONTROL 12'h000
`define OFS_STATUS 12'h004
`define OFS_LAST_CODES 12'h008
`define OFS_COUNT 12'h00c

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define CTL_REPLY_MODE_BIT 0
`define CTL_RESET_VALUE 32'h00000001

// ---------------------------------------------------------------
// Protocol codes
// ---------------------------------------------------------------
`define FC_READ 8'h03
`define FC_WRITE_ONE 8'h06
`define FC_DIAG 8'h08
`define FC_WRITE_MULTI 8'h10
`define FC_READ_WRITE 8'h17
`define FC_EXCEPTION_FLAG 8'h80
`define DIAG_SUB_ECHO 16'h0000
`define EXC_INVALID_FUNCTION 8'h01
`define EXC_INVALID_ADDRESS 8'h02
`define EXC_INVALID_DATA 8'h03
`define EXC_SLAVE_ERROR 8'h04
`define CERR_NONE 8'h00
`define CERR_FUNC_ADDR 8'h88
`define CERR_TOOL_BUSY 8'h89
`define CERR_NV_BUSY 8'h8a
`define CERR_DATA_RANGE 8'h8c
`define CERR_EXEC_DISABLED 8'h8d
`define ADDR_LAST 16'h57ff
`define ADDR_END 17'h05800
`define MAX_READ_COUNT 16'h007d
`define MAX_WRITE_COUNT 16'h007b
`define MAX_RW_WRITE_COUNT 16'h0079
`define BROADCAST_ADDR 8'h00
`define CRC_INIT 16'hffff
`define CRC_POLY 16'ha001

`endif

/* File: logic/crc16_engine.v */
/*
 * Byte-serial CRC-16 engine, one bit per clock, reflected polynomial.
 * Assumes a start pulse to preset, then one byte at a time while not busy.
 */
`timescale 1ns/1ps
`include "exception_responder_regs.vh"

module crc16_engine (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // Control
    input wire clear,
    input wire byte_valid,
    input wire [7:0] byte_data,
    // Result
    output reg busy,
    output reg [15:0] crc
);

reg [2:0] bit_cnt_reg;
wire [15:0] mixed;

// Shift one bit right and fold in the polynomial when a one drops out.
assign mixed = crc >> 1;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        crc <= `CRC_INIT;
        busy <= 1'b0;
        bit_cnt_reg <= 3'h0;
    end else if (clear) begin
        crc <= `CRC_INIT;
        busy <= 1'b0;
        bit_cnt_reg <= 3'h0;
    end else if (byte_valid && !busy) begin
        crc <= crc ^ {8'h00, byte_data};
        busy <= 1'b1;
        bit_cnt_reg <= 3'h0;
    end else if (busy) begin
        crc <= crc[0] ? (mixed ^ `CRC_POLY) : mixed;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
            busy <= 1'b0;
        end
    end
end

endmodule

/* File: tb/exc_resp_checker.sv */
/*
 * Concurrent checks on the reply stream and bus answers of the exception responder.
 * Assumes it is bound to the responder and sees only its ports.
 */
`timescale 1ns/1ps
module exc_resp_checker (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // Query side
    input wire logic query_valid,
    input wire logic [7:0] query_slave_addr,
    input wire logic [7:0] query_function,
    input wire logic normal_go,
    // Reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_ready
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [2:0] idx_reg;
    logic frame_reg;
    logic [7:0] func_reg;
    wire logic idle = !frame_reg && !tx_valid;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Tracks the byte position in a reply and the function of the query taken.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_reg <= 3'h0;
            frame_reg <= 1'b0;
            func_reg <= 8'h00;
        end else begin
            if (tx_valid && tx_ready) idx_reg <= tx_last ? 3'h0 : idx_reg + 3'h1;
            if (tx_valid) frame_reg <= !(tx_ready && tx_last);
            if (query_valid && idle) func_reg <= query_function;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_query_taken;
        query_valid && idle && query_slave_addr != 8'h00;
    endsequence
    sequence s_byte_held;
        tx_valid && !tx_ready;
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_query_answer: assert property (s_query_taken |=> normal_go || tx_valid)
        else $error("query got no answer");
    chk_addr_first: assert property (s_query_taken ##1 tx_valid |->
        tx_data == $past(query_slave_addr))
        else $error("first reply byte is not the slave address");
    chk_func_flag: assert property (tx_valid && idx_reg == 3'h1 |->
        tx_data == func_reg + 8'h80)
        else $error("function byte lacks the exception flag");
    chk_code_range: assert property (tx_valid && idx_reg == 3'h2 |->
        tx_data inside {8'h01, 8'h02, 8'h03, 8'h04})
        else $error("exception code out of range");
    chk_last_fifth: assert property (tx_valid && tx_last |-> idx_reg == 3'h4)
        else $error("last flag not on the fifth byte");
    chk_byte_held: assert property (s_byte_held |=>
        tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("reply byte changed before acceptance");
    chk_crc_gap: assert property ($fell(tx_valid) && idx_reg == 3'h3 |-> ##[1:30] tx_valid)
        else $error("check bytes did not follow");
    chk_broadcast_quiet: assert property (query_valid && idle && query_slave_addr == 8'h00
        |=> !tx_valid [*3])
        else $error("reply sent to a broadcast");
    chk_normal_quiet: assert property (normal_go |=> !tx_valid [*2])
        else $error("normal decision followed by an exception frame");
endmodule

bind modbus_exception_responder exc_resp_checker u_exc_resp_checker (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .query_valid(query_valid), .query_slave_addr(query_slave_addr),
    .query_function(query_function), .normal_go(normal_go), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

/* File: tb/reply_sink.sv */
/*
 * Bus master side of the reply stream: accepts and collects reply bytes.
 * Assumes the responder's valid/ready stream and a pace chosen by the bench.
 */
`timescale 1ns/1ps
module reply_sink (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Reply stream
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    output logic tx_ready,
    // Pace and results
    input wire logic slow,
    output logic [39:0] frame_bytes,
    output logic [7:0] frame_count
);
    logic [1:0] pace_reg;
    // Accepts at full rate or one cycle in four, shifting bytes in arrival order.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pace_reg <= 2'h0;
            tx_ready <= 1'b0;
            frame_bytes <= 40'h0;
            frame_count <= 8'h00;
        end else begin
            pace_reg <= pace_reg + 2'h1;
            tx_ready <= !slow || pace_reg == 2'h3;
            if (tx_valid && tx_ready) begin
                frame_bytes <= {frame_bytes[31:0], tx_data};
                if (tx_last) frame_count <= frame_count + 8'h01;
            end
        end
    end
endmodule

/* File: tb/testbench.sv */
/*
 * Self-checking bench for the exception responder: bus tasks and query scenarios.
 * Assumes the responder, the reply sink and the bound checker are compiled.
 */
`timescale 1ns/1ps
module testbench;
    logic hclk, hresetn, hsel, hwrite, query_valid, query_too_long, query_value_out_of_range;
    logic tool_busy_pin, internal_processing_busy_pin, nv_alarm_pin, exec_disabled_pin;
    logic tx_ready, slow, normal_go, tx_valid, tx_last, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0] query_slave_addr, query_function, query_byte_count, tx_data, comm_error_code;
    logic [15:0] query_start_addr, query_count, query_sub_function;
    logic [39:0] frame_bytes;
    logic [7:0] frame_count;
    logic [7:0] fcs [5] = '{8'h03, 8'h06, 8'h08, 8'h10, 8'h17};
    int err_total, num_checks, exp_count;
    wire logic hready = hreadyout;

    modbus_exception_responder u_modbus_exception_responder (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .query_valid(query_valid), .query_slave_addr(query_slave_addr),
        .query_function(query_function), .query_start_addr(query_start_addr),
        .query_count(query_count), .query_byte_count(query_byte_count),
        .query_sub_function(query_sub_function), .query_too_long(query_too_long),
        .query_value_out_of_range(query_value_out_of_range), .tool_busy_pin(tool_busy_pin),
        .internal_processing_busy_pin(internal_processing_busy_pin),
        .nv_alarm_pin(nv_alarm_pin), .exec_disabled_pin(exec_disabled_pin),
        .normal_go(normal_go), .comm_error_code(comm_error_code), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));
    reply_sink u_reply_sink (.hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow),
        .frame_bytes(frame_bytes), .frame_count(frame_count));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One single AHB-Lite transfer; read data is taken at the data phase's edge.
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Reference check sum over the three leading reply bytes.
    function automatic logic [15:0] crc16(input logic [23:0] b);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 2; i >= 0; i--) begin
            c = c ^ {8'h00, b[i*8 +: 8]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // Sends one query with given conditions and checks decision, frame and code.
    task automatic run(input logic [7:0] sa, fc, input logic [15:0] st, cnt,
        input logic [7:0] bc, input logic [15:0] sub, input logic [1:0] fl,
        input logic [3:0] pn, input logic [7:0] ec, ce);
        logic [7:0] n0;
        logic [23:0] head;
        logic [15:0] c;
        logic go;
        {exec_disabled_pin, nv_alarm_pin, internal_processing_busy_pin, tool_busy_pin} <= pn;
        repeat (5) @(posedge hclk);
        n0 = frame_count;
        go = 1'b0;
        head = {sa, fc + 8'h80, ec};
        c = crc16(head);
        query_valid <= 1'b1;
        query_slave_addr <= sa;
        query_function <= fc;
        query_start_addr <= st;
        query_count <= cnt;
        query_byte_count <= bc;
        query_sub_function <= sub;
        {query_too_long, query_value_out_of_range} <= fl;
        @(posedge hclk);
        query_valid <= 1'b0;
        repeat (60) begin
            @(posedge hclk);
            if (normal_go === 1'b1) go = 1'b1;
        end
        check("normal_go", go, ec == 8'h00);
        check("frames", frame_count - n0, ec != 8'h00 && sa != 8'h00);
        if (ec != 8'h00 && sa != 8'h00)
            check("frame", frame_bytes, {head, c[7:0], c[15:8]});
        check("comm code", comm_error_code, ce);
        if (ce != 8'h00) exp_count++;
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and scenarios
    // ------------------------------------------------------------
    // Free-running bus clock.
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Cuts a hang short.
    initial begin
        repeat (8000) @(posedge hclk);
        err_total++;
        conclude;
    end
    // Main sequence of register and query scenarios.
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, query_valid, slow} = '0;
        {query_slave_addr, query_function, query_start_addr, query_count} = '0;
        {query_byte_count, query_sub_function, query_too_long, query_value_out_of_range} = '0;
        {tool_busy_pin, internal_processing_busy_pin, nv_alarm_pin, exec_disabled_pin} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, 12'h000, 32'h0);
        check("control", rd, 32'h1);
        bus(1'b1, 12'h010, 32'hffffffff);
        bus(1'b0, 12'h010, 32'h0);
        check("unmapped", rd, 32'h0);
        run(8'h01, 8'h10, 16'h0480, 16'h0004, 8'h08, 16'h0, 2'b0, 4'h1, 8'h04, 8'h89);
        check("example", frame_bytes, 40'h0190044dc3);
        foreach (fcs[i]) run(8'h07, fcs[i], 16'h5800, 16'h1, 8'h02, 16'h1, 2'b0, 4'h0,
            fcs[i] == 8'h08 ? 8'h01 : 8'h02, 8'h88);
        slow <= 1'b1;
        run(8'h01, 8'h05, 16'h0, 16'h1, 8'h02, 16'h0, 2'b0, 4'h0, 8'h01, 8'h88);
        run(8'h02, 8'h03, 16'h57ff, 16'h1, 8'h02, 16'h0, 2'b0, 4'h0, 8'h02, 8'h88);
        run(8'h02, 8'h03, 16'h57fe, 16'h1, 8'h02, 16'h0, 2'b0, 4'h0, 8'h00, 8'h00);
        run(8'h03, 8'h03, 16'h0, 16'h0, 8'h00, 16'h0, 2'b0, 4'h0, 8'h03, 8'h8c);
        run(8'h03, 8'h10, 16'h0, 16'h2, 8'h03, 16'h0, 2'b0, 4'h0, 8'h03, 8'h8c);
        run(8'h03, 8'h03, 16'h0, 16'h7e, 8'h00, 16'h0, 2'b0, 4'h0, 8'h03, 8'h8c);
        run(8'h03, 8'h03, 16'h0, 16'h7d, 8'h00, 16'h0, 2'b0, 4'h0, 8'h00, 8'h00);
        run(8'h03, 8'h10, 16'h0, 16'h1, 8'h02, 16'h0, 2'b10, 4'h0, 8'h03, 8'h8c);
        slow <= 1'b0;
        run(8'h04, 8'h03, 16'h0, 16'h1, 8'h00, 16'h0, 2'b0, 4'h2, 8'h04, 8'h8a);
        run(8'h04, 8'h03, 16'h0, 16'h1, 8'h00, 16'h0, 2'b0, 4'h4, 8'h04, 8'h8a);
        run(8'h04, 8'h06, 16'h0, 16'h1, 8'h00, 16'h0, 2'b01, 4'h0, 8'h04, 8'h8c);
        run(8'h04, 8'h03, 16'h0, 16'h1, 8'h00, 16'h0, 2'b0, 4'h8, 8'h04, 8'h8d);
        bus(1'b0, 12'h008, 32'h0);
        check("last codes", rd[15:0], 16'h8d04);
        bus(1'b0, 12'h004, 32'h0);
        check("status", rd, 32'h8);
        run(8'h05, 8'h05, 16'h0, 16'h0, 8'h00, 16'h0, 2'b0, 4'h1, 8'h01, 8'h88);
        run(8'h05, 8'h03, 16'h5800, 16'h0, 8'h00, 16'h0, 2'b0, 4'h1, 8'h02, 8'h88);
        run(8'h05, 8'h03, 16'h0, 16'h0, 8'h00, 16'h0, 2'b0, 4'h1, 8'h03, 8'h8c);
        run(8'h00, 8'h05, 16'h0, 16'h1, 8'h02, 16'h0, 2'b0, 4'h0, 8'h01, 8'h88);
        bus(1'b1, 12'h000, 32'h0);
        run(8'h06, 8'h03, 16'h0, 16'h1, 8'h00, 16'h0, 2'b0, 4'h1, 8'h00, 8'h89);
        bus(1'b1, 12'h000, 32'h1);
        bus(1'b1, 12'h00c, 32'h0);
        bus(1'b0, 12'h00c, 32'h0);
        check("count", rd, exp_count);
        conclude;
    end
endmodule
